// *** tcl_pkg.sv ***
// Notes on behaviour
// - bytes 0 and 1 hold segment checksum word
// - walk starts at tag offset two
// - byte after tag is value length
// - next tag is tag plus two plus length
// - walk until records reach segment top
// - records found by tag match, not address
// - tags FE empty, 01 oscillator, 08 converter
// - oscillator pairs: even step, odd range byte
// - apply range byte and step byte
// - optional fixed absolute oscillator record location
// - xor of 31 words equals stored checksum
// - converter record: eight words, gain, offset
package tcl_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   localparam logic [15:0] SEG_BASE_ADDR = 16'h10C0;
   localparam logic [6:0] SEG_BYTES = 7'h40;
   localparam logic [6:0] SEG_LAST_IDX = 7'h3F;
   localparam logic [6:0] FIRST_TAG_OFF = 7'h02;
   localparam logic [8:0] HDR_BYTES = 9'h002;
   localparam logic [8:0] SEG_TOP_NEXT = 9'h040;
   localparam logic [7:0] TAG_EMPTY_VAL = 8'hFE;
   localparam logic [7:0] OSC_CAL_TAG_VAL = 8'h01;
   localparam logic [7:0] CONV_CAL_TAG_VAL = 8'h08;
   localparam logic [7:0] OSC_REC_LEN = 8'h08;
   localparam logic [7:0] CONV_REC_LEN = 8'h10;
   localparam logic [5:0] FIXED_OSC_VALUE_OFF = 6'h38;
   localparam logic [5:0] CONV_GAIN_OFF = 6'h00;
   localparam logic [5:0] CONV_OFFSET_OFF = 6'h02;
   localparam logic [15:0] CSUM_RESET = 16'h0000;

   ////////////////////////////////////////////////////////////////////////////////
   typedef enum logic [1:0] {
      FREQ_16MHZ = 2'b00,
      FREQ_12MHZ = 2'b01,
      FREQ_8MHZ = 2'b10,
      FREQ_1MHZ = 2'b11
   } tcl_freq_e;

   typedef enum logic [1:0] {
      TAG_KIND_OTHER = 2'b00,
      TAG_KIND_EMPTY = 2'b01,
      TAG_KIND_OSC = 2'b10,
      TAG_KIND_CONV = 2'b11
   } tcl_tag_e;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_FETCH = 3'b001,
      ST_CHECK = 3'b010,
      ST_WALK = 3'b011,
      ST_APPLY = 3'b100,
      ST_DONE = 3'b101,
      ST_FAIL = 3'b110
   } tcl_state_e;

   typedef struct packed {
      logic req;
      logic [15:0] addr;
   } tcl_flash_req_s;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } tcl_flash_rsp_s;

   typedef struct packed {
      logic write;
      logic [7:0] rangeSel;
      logic [7:0] step;
   } tcl_clock_cal_s;

   typedef struct packed {
      logic valid;
      logic [15:0] gain;
      logic [15:0] offset;
   } tcl_conv_cal_s;

   typedef struct packed {
      logic [7:0] lo;
      logic [7:0] hi;
   } tcl_xor_s;

   typedef struct packed {
      tcl_state_e state;
      logic [6:0] idx;
      logic [6:0] off;
      logic oscOk;
      logic [5:0] oscBase;
      logic convOk;
      logic [5:0] convBase;
      tcl_clock_cal_s clk;
      tcl_conv_cal_s conv;
      logic done;
      logic error;
      logic csumBad;
      logic oscMissing;
   } tcl_loader_s;

endpackage

// *** tcl_xor_acc.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcl_xor_acc (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // byte stream
   input wire logic clear,
   input wire logic enable,
   input wire logic oddByte,
   input wire logic [7:0] data,
   // folded word
   output logic [15:0] sum
);
   import tcl_pkg::*;

   tcl_xor_s acc_reg;
   tcl_xor_s acc_next;

   ////////////////////////////////////////////////////////////////////////////////
   // low byte at even address, high byte at odd
   always_comb begin
      acc_next = acc_reg;
      if (clear) begin
         acc_next = tcl_xor_s'(CSUM_RESET);
      end else if (enable && oddByte) begin
         acc_next.hi = acc_reg.hi ^ data;
      end else if (enable) begin
         acc_next.lo = acc_reg.lo ^ data;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         acc_reg <= tcl_xor_s'(CSUM_RESET);
      end else begin
         acc_reg <= acc_next;
      end
   end

   assign sum = {acc_reg.hi, acc_reg.lo};
endmodule
`default_nettype wire

// *** tcl_tag_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcl_tag_decode (
   // tag byte
   input wire logic [7:0] tag,
   // classification
   output tcl_pkg::tcl_tag_e kind
);
   import tcl_pkg::*;

   always_comb begin
      case (tag)
         TAG_EMPTY_VAL: begin
            kind = TAG_KIND_EMPTY;
         end
         OSC_CAL_TAG_VAL: begin
            kind = TAG_KIND_OSC;
         end
         CONV_CAL_TAG_VAL: begin
            kind = TAG_KIND_CONV;
         end
         default: begin
            kind = TAG_KIND_OTHER;
         end
      endcase
   end
endmodule
`default_nettype wire

// *** tcl_loader.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcl_loader (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // control
   input wire logic start,
   input wire logic fixedMode,
   input wire tcl_pkg::tcl_freq_e freqSel,
   // flash information memory
   output tcl_pkg::tcl_flash_req_s flashReq,
   input wire tcl_pkg::tcl_flash_rsp_s flashRsp,
   // consumers
   output tcl_pkg::tcl_clock_cal_s clockCal,
   output tcl_pkg::tcl_conv_cal_s convCal,
   // status
   output logic busy,
   output logic done,
   output logic error,
   output logic checksumBad,
   output logic oscMissing
);
   import tcl_pkg::*;

   tcl_loader_s s_reg;
   tcl_loader_s s_next;
   logic [7:0] segBuf [0:63];
   logic [15:0] csum;
   logic csumClear;
   logic csumEn;
   tcl_tag_e tagKind;
   logic [7:0] curTag;
   logic [7:0] curLen;
   logic [8:0] nextOff;
   logic [5:0] oscPtr;
   logic [5:0] stepIdx;
   logic [5:0] rangeIdx;
   logic [5:0] gainIdx;
   logic [5:0] offsIdx;

   ////////////////////////////////////////////////////////////////////////////////
   // whole segment is copied once so checksum and walk see the same bytes
   always_ff @(posedge clock) begin
      if (s_reg.state == ST_FETCH && flashRsp.valid) begin
         segBuf[s_reg.idx[5:0]] <= flashRsp.data;
      end
   end

   assign csumClear = (s_reg.state == ST_IDLE) || (s_reg.state == ST_DONE)
      || (s_reg.state == ST_FAIL);
   // the two checksum bytes are left out of the fold
   assign csumEn = (s_reg.state == ST_FETCH) && flashRsp.valid
      && (s_reg.idx >= FIRST_TAG_OFF);

   tcl_xor_acc u_xor (
      .clock(clock),
      .reset_n(reset_n),
      .clear(csumClear),
      .enable(csumEn),
      .oddByte(s_reg.idx[0]),
      .data(flashRsp.data),
      .sum(csum)
   );

   ////////////////////////////////////////////////////////////////////////////////
   assign curTag = segBuf[s_reg.off[5:0]];
   assign curLen = segBuf[6'(s_reg.off[5:0] + 6'h01)];
   assign nextOff = {2'b00, s_reg.off} + HDR_BYTES + {1'b0, curLen};

   tcl_tag_decode u_dec (
      .tag(curTag),
      .kind(tagKind)
   );

   // fixed mode trusts the common location and needs no tag
   assign oscPtr = fixedMode ? FIXED_OSC_VALUE_OFF : s_reg.oscBase;
   assign stepIdx = 6'(oscPtr + {2'b00, freqSel, 1'b0});
   assign rangeIdx = 6'(oscPtr + {2'b00, freqSel, 1'b1});
   assign gainIdx = 6'(s_reg.convBase + CONV_GAIN_OFF);
   assign offsIdx = 6'(s_reg.convBase + CONV_OFFSET_OFF);

   ////////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_next = s_reg;
      s_next.clk.write = 1'b0;
      s_next.conv.valid = 1'b0;
      case (s_reg.state)
         ST_IDLE, ST_DONE, ST_FAIL: begin
            if (start) begin
               s_next.state = ST_FETCH;
               s_next.idx = 7'h00;
               s_next.off = FIRST_TAG_OFF;
               s_next.oscOk = 1'b0;
               s_next.convOk = 1'b0;
               s_next.done = 1'b0;
               s_next.error = 1'b0;
               s_next.csumBad = 1'b0;
               s_next.oscMissing = 1'b0;
            end
         end
         ST_FETCH: begin
            if (flashRsp.valid) begin
               s_next.idx = 7'(s_reg.idx + 7'h01);
               if (s_reg.idx == SEG_LAST_IDX) begin
                  s_next.state = ST_CHECK;
               end
            end
         end
         ST_CHECK: begin
            if (csum != {segBuf[1], segBuf[0]}) begin
               s_next.state = ST_FAIL;
               s_next.error = 1'b1;
               s_next.csumBad = 1'b1;
            end else begin
               s_next.state = ST_WALK;
            end
         end
         ST_WALK: begin
            // a header that does not fit below the top is an overrun
            if (s_reg.off >= SEG_LAST_IDX || nextOff > SEG_TOP_NEXT) begin
               s_next.state = ST_FAIL;
               s_next.error = 1'b1;
            end else begin
               if (tagKind == TAG_KIND_OSC && curLen >= OSC_REC_LEN) begin
                  s_next.oscOk = 1'b1;
                  s_next.oscBase = 6'(s_reg.off + 7'h02);
               end
               if (tagKind == TAG_KIND_CONV && curLen == CONV_REC_LEN) begin
                  s_next.convOk = 1'b1;
                  s_next.convBase = 6'(s_reg.off + 7'h02);
               end
               // empty and unknown records are simply stepped over
               if (nextOff == SEG_TOP_NEXT) begin
                  s_next.state = ST_APPLY;
               end else begin
                  s_next.off = nextOff[6:0];
               end
            end
         end
         ST_APPLY: begin
            if (fixedMode || s_reg.oscOk) begin
               s_next.clk.write = 1'b1;
               s_next.clk.rangeSel = segBuf[rangeIdx];
               s_next.clk.step = segBuf[stepIdx];
            end else begin
               s_next.oscMissing = 1'b1;
            end
            if (s_reg.convOk) begin
               s_next.conv.valid = 1'b1;
               s_next.conv.gain = {segBuf[6'(gainIdx + 6'h01)], segBuf[gainIdx]};
               s_next.conv.offset = {segBuf[6'(offsIdx + 6'h01)], segBuf[offsIdx]};
            end
            s_next.done = 1'b1;
            s_next.state = ST_DONE;
         end
         default: begin
            s_next.state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         s_reg <= '{state: ST_IDLE, off: FIRST_TAG_OFF, default: '0};
      end else begin
         s_reg <= s_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   assign flashReq.req = (s_reg.state == ST_FETCH);
   assign flashReq.addr = SEG_BASE_ADDR + {9'h000, s_reg.idx};
   assign clockCal = s_reg.clk;
   assign convCal = s_reg.conv;
   assign busy = (s_reg.state == ST_FETCH) || (s_reg.state == ST_CHECK)
      || (s_reg.state == ST_WALK) || (s_reg.state == ST_APPLY);
   assign done = s_reg.done;
   assign error = s_reg.error;
   assign checksumBad = s_reg.csumBad;
   assign oscMissing = s_reg.oscMissing;
endmodule
`default_nettype wire

// *** tcl_flash_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcl_flash_model (
   // clock and pacing
   input wire logic clock,
   input wire logic slow,
   // flash port
   input wire tcl_pkg::tcl_flash_req_s flashReq,
   output tcl_pkg::tcl_flash_rsp_s flashRsp
);
   logic [7:0] mem [64];
   logic tog = 1'b0;
   ////////////////////////////////////////////////////////////////////////////////
   // plain always: the start value comes from the declaration
   always @(posedge clock) begin
      tog <= ~tog;
   end
   // slow mode answers every other cycle; unanswered data is inverted, never stale
   assign flashRsp.valid = flashReq.req && (!slow || tog);
   assign flashRsp.data = flashRsp.valid ? mem[flashReq.addr[5:0]] : ~mem[flashReq.addr[5:0]];
endmodule
`default_nettype wire

// *** tcl_loader_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcl_loader_asserts (
   // watched ports
   input wire logic clock,
   input wire logic reset_n,
   input wire tcl_pkg::tcl_flash_req_s flashReq,
   input wire tcl_pkg::tcl_flash_rsp_s flashRsp,
   input wire tcl_pkg::tcl_clock_cal_s clockCal,
   input wire logic done,
   input wire logic error,
   input wire logic checksumBad
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!reset_n);
   sequence s_take;
      flashReq.req && flashRsp.valid;
   endsequence
   sequence s_last;
      s_take ##0 flashReq.addr == 16'h10FF;
   endsequence
   a_first_addr: assert property ($rose(flashReq.req) |-> flashReq.addr == 16'h10C0)
      else $error("fetch does not start at segment base");
   a_addr_step: assert property (s_take ##0 flashReq.addr != 16'h10FF
      |=> flashReq.req && flashReq.addr == $past(flashReq.addr) + 16'h0001)
      else $error("address did not advance by one");
   a_addr_hold: assert property (flashReq.req && !flashRsp.valid |=> $stable(flashReq.addr))
      else $error("address moved without acceptance");
   a_addr_range: assert property (flashReq.req |-> flashReq.addr inside {[16'h10C0:16'h10FF]})
      else $error("address outside segment");
   a_walk_ends: assert property (s_last |-> ##[1:40] (done || error))
      else $error("walk did not finish");
   a_write_pulse: assert property (clockCal.write |=> !clockCal.write)
      else $error("clock write longer than one cycle");
   a_cal_hold: assert property (!clockCal.write |-> $stable({clockCal.rangeSel, clockCal.step}))
      else $error("clock values changed without write");
   a_err_nowrite: assert property (error |-> !clockCal.write && !done)
      else $error("write or done with error");
   a_bad_flag: assert property (checksumBad |-> error)
      else $error("checksum flag without error");
endmodule
bind tcl_loader tcl_loader_asserts chk_u (.clock(clock), .reset_n(reset_n),
   .flashReq(flashReq), .flashRsp(flashRsp), .clockCal(clockCal), .done(done),
   .error(error), .checksumBad(checksumBad));
`default_nettype wire

// *** tcl_loader_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tcl_loader_tb;
   import tcl_pkg::*;
   typedef struct packed {tcl_freq_e f; logic [7:0] r; logic [7:0] s;} tcl_row_s;
   logic clock, reset_n, start, fixedMode, slow, busy, done, error, checksumBad, oscMissing;
   tcl_freq_e freqSel;
   tcl_flash_req_s flashReq;
   tcl_flash_rsp_s flashRsp;
   tcl_clock_cal_s clockCal;
   tcl_conv_cal_s convCal;
   int error_cnt = 0, compares = 0, writes = 0, convs = 0;
   logic [7:0] prevR;
   tcl_row_s rows [4] = '{'{FREQ_16MHZ, 8'h41, 8'h40}, '{FREQ_12MHZ, 8'h43, 8'h42},
      '{FREQ_8MHZ, 8'h45, 8'h44}, '{FREQ_1MHZ, 8'h47, 8'h46}};
   tcl_loader dut_u (.clock(clock), .reset_n(reset_n), .start(start), .fixedMode(fixedMode),
      .freqSel(freqSel), .flashReq(flashReq), .flashRsp(flashRsp), .clockCal(clockCal),
      .convCal(convCal), .busy(busy), .done(done), .error(error), .checksumBad(checksumBad),
      .oscMissing(oscMissing));
   tcl_flash_model mem_u (.clock(clock), .slow(slow), .flashReq(flashReq), .flashRsp(flashRsp));
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end
   always @(posedge clock) begin
      if (clockCal.write === 1'b1) writes++;
      if (convCal.valid === 1'b1) convs++;
   end
   task automatic give_verdict();
      $display("compares=%0d errors=%0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         error_cnt++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // checksum is the xor of the 31 words above it
   task automatic seal();
      logic [15:0] x;
      x = 16'h0000;
      for (int k = 1; k < 32; k++) x ^= {mem_u.mem[2*k+1], mem_u.mem[2*k]};
      {mem_u.mem[1], mem_u.mem[0]} = x;
   endtask
   task automatic blank(input logic [7:0] t, input logic [7:0] l);
      for (int i = 0; i < 64; i++) mem_u.mem[i] = 8'hFF;
      mem_u.mem[2] = t;
      mem_u.mem[3] = l;
   endtask
   task automatic run(input logic fx, input tcl_freq_e f);
      int n;
      seal();
      writes = 0;
      convs = 0;
      prevR = clockCal.rangeSel;
      fixedMode = fx;
      freqSel = f;
      start = 1'b1;
      @(posedge clock) #1 start = 1'b0;
      chk({15'h0000, busy}, 16'h0001);
      for (n = 0; n < 300 && done !== 1'b1 && error !== 1'b1; n++) @(posedge clock) #1;
      if (n == 300) begin
         error_cnt++;
         $display("ERROR %0t walk hung", $time);
         give_verdict();
      end
      @(posedge clock) #1;
   endtask
   initial begin
      {reset_n, start, fixedMode, slow} = 4'b0000;
      freqSel = FREQ_16MHZ;
      repeat (20) @(posedge clock);
      #1 reset_n = 1'b1;
      chk(flashReq.addr, 16'h10C0);
      chk({busy, flashReq.req, done, error, clockCal.write, convCal.valid}, 16'h0000);
      for (int i = 0; i < 4; i++) begin
         slow = i[0];
         blank(8'hFE, 8'h16);
         {mem_u.mem[26], mem_u.mem[27], mem_u.mem[44], mem_u.mem[45]} = 32'h0810_FE08;
         {mem_u.mem[54], mem_u.mem[55]} = 16'h0108;
         for (int k = 0; k < 16; k++) mem_u.mem[28+k] = 8'h20 + 8'(k);
         for (int k = 0; k < 8; k++) mem_u.mem[56+k] = 8'h40 + 8'(k);
         run(1'b0, rows[i].f);
         chk({clockCal.rangeSel, clockCal.step}, {rows[i].r, rows[i].s});
         chk(16'(writes), 16'h0001);
         chk(16'(convs), 16'h0001);
         chk({convCal.gain}, 16'h2120);
         chk({convCal.offset}, 16'h2322);
         chk({15'h0000, done}, 16'h0001);
         $display("row %0d done", i);
      end
      mem_u.mem[0] = ~mem_u.mem[0];
      writes = 0;
      prevR = clockCal.rangeSel;
      start = 1'b1;
      @(posedge clock) #1 start = 1'b0;
      // slow memory needs two cycles a byte
      repeat (200) @(posedge clock);
      #1 chk({error, checksumBad, clockCal.rangeSel}, {2'b11, prevR});
      chk(16'(writes), 16'h0000);
      $display("checksum case done");
      // reset dropped in the middle of a fetch
      start = 1'b1;
      @(posedge clock) #1 start = 1'b0;
      repeat (10) @(posedge clock);
      #1 reset_n = 1'b0;
      #1 chk({busy, flashReq.req, error, clockCal.rangeSel}, 16'h0000);
      @(posedge clock) #1 reset_n = 1'b1;
      chk(flashReq.addr, 16'h10C0);
      $display("mid-run reset case done");
      // oscillator record moved to the first slot
      blank(8'h01, 8'h08);
      for (int k = 4; k < 12; k++) mem_u.mem[k] = 8'h60 + 8'(k);
      {mem_u.mem[12], mem_u.mem[13]} = 16'hFE32;
      run(1'b0, FREQ_8MHZ);
      chk({clockCal.rangeSel, clockCal.step}, 16'h6968);
      run(1'b1, FREQ_1MHZ);
      chk({clockCal.rangeSel, clockCal.step}, 16'hFFFF);
      blank(8'hFE, 8'h3C);
      run(1'b0, FREQ_1MHZ);
      chk({oscMissing, error, 8'(writes)}, 10'h200);
      chk(16'(convs), 16'h0000);
      blank(8'hFE, 8'h3D);
      run(1'b0, FREQ_1MHZ);
      chk({error, checksumBad, 8'(writes)}, 10'h200);
      $display("awkward cases done");
      give_verdict();
   end
endmodule
`default_nettype wire
